/* pkg/ucodec_map.svh */
// Constants for the USB 2.0 line-state and NRZI codec.
`ifndef UCODEC_MAP_SVH
`define UCODEC_MAP_SVH
// Sampling clock cycles per bit.
`define UCODEC_SPB 3'h4
// Half-bit phase; one less is loaded after a transition so the next sample lands mid-bit.
`define UCODEC_HALF 3'h2
// Run of ones after which a zero is stuffed.
`define UCODEC_STUFF_RUN 3'h6
// Cycles without any line change that mark the bus as idle.
`define UCODEC_IDLE_CNT 6'h20
// Longest SE1 in cycles still taken as a passing transition.
`define UCODEC_SE1_TOL 2'h2
`endif

/* pkg/ucodec_pkg.sv */
// Types shared by the USB 2.0 line-state and NRZI codec.
`default_nettype none
package ucodec_pkg;
	typedef enum logic [1:0] {
		LS_SE0 = 2'h0,
		LS_J = 2'h1,
		LS_K = 2'h2,
		LS_SE1 = 2'h3
	} ucodec_line_e;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_DATA = 2'h1,
		TX_STUFF = 2'h3
	} ucodec_tx_e;

	typedef struct packed {
		logic dp;
		logic dm;
	} ucodec_pins_s;
endpackage : ucodec_pkg
`default_nettype wire

/* rtl/ucodec_top.sv */
// Bit-level codec for a legacy USB 2.0 differential pair.
// ============================================================
// Summary of operation
// - Both low is SE0, both high SE1.
// - J and K polarity follows the speed.
// - Data travels only as J or K.
// - Never drive SE1; flag lasting SE1.
// - NRZI: one holds, zero toggles.
// - Realign sampling phase on J/K transitions.
// - Stuff a zero after six ones.
// - Stuffing happens even before a zero.
// - Receiver drops the zero after six ones.
// - Idle D+ high is full, D- low.
`timescale 1ns/1ps
`default_nettype none
`include "ucodec_map.svh"
module ucodec_top (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic dp_in,
	input wire logic dm_in,
	output logic dp_out,
	output logic dm_out,
	output logic line_oe,
	input wire logic tx_valid,
	input wire logic tx_bit,
	output logic tx_ack,
	output logic rx_valid,
	output logic rx_bit,
	output logic [1:0] line_state,
	output logic speed_ls,
	output logic speed_known,
	output logic rx_se1_err,
	output logic rx_stuff_err
);

	// ============================================================
	// Helpers
	function automatic ucodec_pkg::ucodec_line_e classify(input ucodec_pkg::ucodec_pins_s p, input logic ls);
		if (p.dp == p.dm) begin
			classify = p.dp ? ucodec_pkg::LS_SE1 : ucodec_pkg::LS_SE0;
		end else if (p.dp ^ ls) begin
			classify = ucodec_pkg::LS_J;
		end else begin
			classify = ucodec_pkg::LS_K;
		end
	endfunction : classify

	// Only J or K can come out: the two lines are always complements.
	function automatic ucodec_pkg::ucodec_pins_s line_drive(input logic j, input logic ls);
		line_drive.dp = j ^ ls;
		line_drive.dm = ~(j ^ ls);
	endfunction : line_drive

	// ============================================================
	// Input synchroniser and line classification
	ucodec_pkg::ucodec_pins_s sync1_reg, sync2_reg, prev_reg;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg <= '0;
		end else begin
			sync1_reg <= '{dp: dp_in, dm: dm_in};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	logic speed_ls_reg, speed_ls_next, speed_known_reg, speed_known_next;
	logic [5:0] stable_reg, stable_next;
	logic [1:0] se1_reg, se1_next;
	logic se1_err_reg, se1_err_next;
	ucodec_pkg::ucodec_line_e state_reg, state_next;
	logic changed, jk_now, jk_prev, transition, idle_seen;

	always_comb begin
		changed = (sync2_reg != prev_reg);
		jk_now = (sync2_reg.dp != sync2_reg.dm);
		jk_prev = (prev_reg.dp != prev_reg.dm);
		transition = changed && jk_now && jk_prev;
		// The first edge after a quiet spell must still start the receiver, so a change ends idle at once.
		idle_seen = (stable_reg == `UCODEC_IDLE_CNT) && !changed;
		stable_next = changed ? '0 : (idle_seen ? stable_reg : stable_reg + 6'h1);
		speed_ls_next = speed_ls_reg;
		speed_known_next = speed_known_reg;
		// The transmitter's own drive would be mistaken for idle, so only listen while released.
		if (idle_seen && jk_now && !line_oe) begin
			speed_ls_next = sync2_reg.dm;
			speed_known_next = 1'b1;
		end
		state_next = classify(sync2_reg, speed_ls_reg);
		se1_next = '0;
		if (state_next == ucodec_pkg::LS_SE1) begin
			se1_next = (se1_reg == `UCODEC_SE1_TOL) ? se1_reg : se1_reg + 2'h1;
		end
		se1_err_next = (se1_reg == `UCODEC_SE1_TOL) && (state_next == ucodec_pkg::LS_SE1);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			speed_ls_reg <= 1'b0;
			speed_known_reg <= 1'b0;
			stable_reg <= '0;
			se1_reg <= '0;
			se1_err_reg <= 1'b0;
			state_reg <= ucodec_pkg::LS_SE0;
		end else begin
			speed_ls_reg <= speed_ls_next;
			speed_known_reg <= speed_known_next;
			stable_reg <= stable_next;
			se1_reg <= se1_next;
			se1_err_reg <= se1_err_next;
			state_reg <= state_next;
		end
	end

	// ============================================================
	// Receiver: clock recovery, NRZI decode and unstuffing
	logic rx_act_reg, rx_act_next, ref_reg, ref_next;
	logic [2:0] phase_reg, phase_next, rx_ones_reg, rx_ones_next, turn_reg, turn_next;
	logic rx_valid_reg, rx_valid_next, rx_bit_reg, rx_bit_next, stuff_err_reg, stuff_err_next;
	logic dec_bit;

	always_comb begin
		rx_act_next = rx_act_reg;
		ref_next = ref_reg;
		phase_next = phase_reg;
		rx_ones_next = rx_ones_reg;
		rx_valid_next = 1'b0;
		rx_bit_next = rx_bit_reg;
		stuff_err_next = 1'b0;
		dec_bit = (sync2_reg.dp == ref_reg);
		// Our own drive still echoes through the synchroniser for a few cycles after release.
		turn_next = {turn_reg[1:0], line_oe};
		if (line_oe || (turn_reg != '0) || !jk_now || idle_seen) begin
			// SE0, SE1 or a quiet line carries no data and ends any run.
			rx_act_next = 1'b0;
			rx_ones_next = '0;
			ref_next = sync2_reg.dp;
			phase_next = `UCODEC_HALF;
		end else if (transition) begin
			rx_act_next = 1'b1;
			phase_next = `UCODEC_HALF - 3'h1;
		end else if (rx_act_reg) begin
			if (phase_reg == '0) begin
				phase_next = `UCODEC_SPB - 3'h1;
				ref_next = sync2_reg.dp;
				if (rx_ones_reg == `UCODEC_STUFF_RUN) begin
					rx_ones_next = '0;
					stuff_err_next = dec_bit;
					// A stuffed zero is swallowed here and never reaches the user.
				end else begin
					rx_valid_next = 1'b1;
					rx_bit_next = dec_bit;
					rx_ones_next = dec_bit ? rx_ones_reg + 3'h1 : '0;
				end
			end else begin
				phase_next = phase_reg - 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_act_reg <= 1'b0;
			turn_reg <= '0;
			ref_reg <= 1'b0;
			phase_reg <= '0;
			rx_ones_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_bit_reg <= 1'b0;
			stuff_err_reg <= 1'b0;
		end else begin
			rx_act_reg <= rx_act_next;
			turn_reg <= turn_next;
			ref_reg <= ref_next;
			phase_reg <= phase_next;
			rx_ones_reg <= rx_ones_next;
			rx_valid_reg <= rx_valid_next;
			rx_bit_reg <= rx_bit_next;
			stuff_err_reg <= stuff_err_next;
		end
	end

	// ============================================================
	// Transmitter: bit stuffing then NRZI
	ucodec_pkg::ucodec_tx_e tx_reg, tx_next;
	logic lvl_reg, lvl_next, ack_reg, ack_next, oe_reg, oe_next;
	logic [2:0] tx_cnt_reg, tx_cnt_next, tx_ones_reg, tx_ones_next;
	ucodec_pkg::ucodec_pins_s pins_reg, pins_next;
	logic take;

	always_comb begin
		tx_next = tx_reg;
		lvl_next = lvl_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_ones_next = tx_ones_reg;
		take = 1'b0;
		case (tx_reg)
			ucodec_pkg::TX_IDLE: begin
				lvl_next = 1'b1;
				tx_ones_next = '0;
				take = tx_valid;
			end
			ucodec_pkg::TX_DATA, ucodec_pkg::TX_STUFF: begin
				if (tx_cnt_reg != '0) begin
					tx_cnt_next = tx_cnt_reg - 3'h1;
				end else if (tx_ones_reg == `UCODEC_STUFF_RUN) begin
					// Stuffed regardless of the pending bit, so the line must change.
					tx_next = ucodec_pkg::TX_STUFF;
					lvl_next = ~lvl_reg;
					tx_ones_next = '0;
					tx_cnt_next = `UCODEC_SPB - 3'h1;
				end else if (tx_valid) begin
					take = 1'b1;
				end else begin
					tx_next = ucodec_pkg::TX_IDLE;
					lvl_next = 1'b1;
					tx_ones_next = '0;
				end
			end
			default: begin
				tx_next = ucodec_pkg::TX_IDLE;
			end
		endcase
		if (take) begin
			tx_next = ucodec_pkg::TX_DATA;
			lvl_next = tx_bit ? lvl_reg : ~lvl_reg;
			tx_ones_next = tx_bit ? tx_ones_reg + 3'h1 : '0;
			tx_cnt_next = `UCODEC_SPB - 3'h1;
		end
		ack_next = take;
		oe_next = (tx_next != ucodec_pkg::TX_IDLE);
		pins_next = line_drive(lvl_next, speed_ls_reg);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_reg <= ucodec_pkg::TX_IDLE;
			lvl_reg <= 1'b1;
			tx_cnt_reg <= '0;
			tx_ones_reg <= '0;
			ack_reg <= 1'b0;
			oe_reg <= 1'b0;
			pins_reg <= '{dp: 1'b1, dm: 1'b0};
		end else begin
			tx_reg <= tx_next;
			lvl_reg <= lvl_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_ones_reg <= tx_ones_next;
			ack_reg <= ack_next;
			oe_reg <= oe_next;
			pins_reg <= pins_next;
		end
	end

	// ============================================================
	// Outputs
	assign dp_out = pins_reg.dp;
	assign dm_out = pins_reg.dm;
	assign line_oe = oe_reg;
	assign tx_ack = ack_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_bit = rx_bit_reg;
	assign line_state = state_reg;
	assign speed_ls = speed_ls_reg;
	assign speed_known = speed_known_reg;
	assign rx_se1_err = se1_err_reg;
	assign rx_stuff_err = stuff_err_reg;

endmodule : ucodec_top
`default_nettype wire

/* bench/ucodec_properties.sv */
// Port-level assertions for the line codec.
`timescale 1ns/1ps
`default_nettype none
module ucodec_properties (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic dp_in,
	input wire logic dm_in,
	input wire logic dp_out,
	input wire logic dm_out,
	input wire logic line_oe,
	input wire logic tx_bit,
	input wire logic tx_ack,
	input wire logic [1:0] line_state,
	input wire logic speed_ls,
	input wire logic speed_known,
	input wire logic rx_se1_err,
	input wire logic rx_stuff_err
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Counts cycles the driven level has not moved, to bound the run that stuffing must break.
	logic [7:0] hold_cnt;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) hold_cnt <= 8'h00;
		else hold_cnt <= (line_oe && $stable(dp_out)) ? hold_cnt + 8'h01 : 8'h00;
	end
	tx_diff_a: assert property (line_oe |-> dp_out != dm_out) else $error("single-ended drive");
	se_dec_a: assert property ($past(arst_n, 4) && $past(dp_in, 3) == $past(dm_in, 3) |->
		line_state == {2{$past(dp_in, 3)}}) else $error("single-ended state wrong");
	jk_dec_a: assert property ($past(arst_n, 4) && $past(dp_in, 3) != $past(dm_in, 3) && $stable(speed_ls) |->
		line_state == ($past(dp_in, 3) ^ speed_ls ? ucodec_pkg::LS_J : ucodec_pkg::LS_K)) else $error("J/K wrong");
	nrzi_one_a: assert property (tx_ack && $past(line_oe) && $past(tx_bit) |-> $stable(dp_out)) else $error("one moved");
	nrzi_zero_a: assert property (tx_ack && $past(line_oe) && !$past(tx_bit) |-> $changed(dp_out)) else $error("zero held");
	ack_gap_a: assert property (tx_ack |=> !tx_ack [*3]) else $error("bit period short");
	stuff_run_a: assert property (hold_cnt <= 8'h1b) else $error("no stuffed transition");
	se1_flag_a: assert property ((dp_in && dm_in && !line_oe) [*6] |-> ##[0:4] rx_se1_err) else $error("SE1 unflagged");
	speed_pick_a: assert property ($rose(speed_known) || $changed(speed_ls) |-> speed_ls == $past(dm_in, 8))
		else $error("speed wrong");
	stuff_seen_c: cover property (rx_stuff_err);
	se1_seen_c: cover property (rx_se1_err);
	ls_seen_c: cover property ($rose(speed_ls));
endmodule : ucodec_properties
bind ucodec_top ucodec_properties ucodec_properties_i (.sys_clk, .arst_n, .dp_in, .dm_in, .dp_out, .dm_out, .line_oe,
	.tx_bit, .tx_ack, .line_state, .speed_ls, .speed_known, .rx_se1_err, .rx_stuff_err);
`default_nettype wire

/* bench/ucodec_far_end.sv */
// Behavioural model of the remote port driving the pair.
`timescale 1ns/1ps
`default_nettype none
module ucodec_far_end (
	input wire logic sys_clk,
	output var ucodec_pkg::ucodec_pins_s pins
);
	logic ls;
	initial begin
		ls = 1'b0;
		pins = 2'b10;
	end
	// Idle J by pull-up: D+ high for full speed, D- high for low speed.
	task automatic idle(input logic l, input int n);
		ls = l;
		pins = {~l, l};
		repeat (n) @(negedge sys_clk);
	endtask : idle
	// Single-ended states carry no data; SE1 only when a test asks for it.
	task automatic se(input logic v, input int n);
		pins = {v, v};
		repeat (n) @(negedge sys_clk);
		pins = {~ls, ls};
	endtask : se
	task automatic send(input logic [15:0] b, input int n, input bit stuff);
		logic j;
		int run;
		j = 1'b1;
		run = 0;
		for (int i = 0; i < n; i++) begin
			j = b[i] ? j : ~j;
			run = b[i] ? run + 1 : 0;
			pins = {j ^ ls, ~(j ^ ls)};
			repeat (4) @(negedge sys_clk);
			if (stuff && run == 6) begin
				j = ~j;
				run = 0;
				pins = {j ^ ls, ~(j ^ ls)};
				repeat (4) @(negedge sys_clk);
			end
		end
		se(1'b0, 8);
	endtask : send
endmodule : ucodec_far_end
`default_nettype wire

/* bench/test_usb2_line_state_nrzi_codec.sv */
// Self-checking bench for the line codec.
`timescale 1ns/1ps
`default_nettype none
module test_usb2_line_state_nrzi_codec;
	logic sys_clk, arst_n, tx_valid, tx_bit, dp_out, dm_out, line_oe, tx_ack, rx_valid, rx_bit;
	logic speed_ls, speed_known, rx_se1_err, rx_stuff_err;
	logic [1:0] line_state;
	ucodec_pkg::ucodec_pins_s far;
	int errors = 0, cmp_count = 0, cyc = 0, se1_n = 0, serr_n = 0;
	logic rxq[$];
	logic [15:0] pay = 16'h017e;
	ucodec_top ucodec_top_i (.sys_clk, .arst_n, .dp_in(line_oe ? dp_out : far.dp), .dm_in(line_oe ? dm_out : far.dm),
		.dp_out, .dm_out, .line_oe, .tx_valid, .tx_bit, .tx_ack, .rx_valid, .rx_bit, .line_state, .speed_ls,
		.speed_known, .rx_se1_err, .rx_stuff_err);
	ucodec_far_end ucodec_far_end_i (.sys_clk, .pins(far));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		cyc++;
		if (rx_valid === 1'b1) rxq.push_back(rx_bit);
		if (rx_se1_err === 1'b1) se1_n++;
		if (rx_stuff_err === 1'b1) serr_n++;
		if (cyc == 5000) begin
			errors++;
			results();
		end
	end
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic t_rx;
		rxq.delete();
		ucodec_far_end_i.send(pay, 10, 1'b1);
		chk(rxq.size() == 10, "rx count");
		for (int i = 0; i < 10; i++) chk(rxq[i] === pay[i], "rx bit");
	endtask : t_rx
	task automatic t_tx;
		logic j, st;
		int run, gap;
		j = 1'b1;
		run = 0;
		for (int i = 0; i < 9; i++) begin
			tx_valid = 1'b1;
			tx_bit = pay[i];
			gap = 0;
			do begin
				@(negedge sys_clk);
				gap++;
			end while (tx_ack !== 1'b1 && gap < 20);
			st = (run == 6);
			if (st) j = ~j;
			if (st) run = 0;
			if (i > 0) chk(gap == (st ? 8 : 4), "tx gap");
			j = pay[i] ? j : ~j;
			run = pay[i] ? run + 1 : 0;
			chk(dp_out === j && dm_out === ~j && line_oe === 1'b1, "tx level");
		end
		tx_valid = 1'b0;
		repeat (10) @(negedge sys_clk);
		chk(line_oe === 1'b0, "tx release");
	endtask : t_tx
	task automatic t_err;
		serr_n = 0;
		ucodec_far_end_i.send(16'h00fe, 8, 1'b0);
		chk(serr_n > 0, "stuff err");
		ucodec_far_end_i.se(1'b1, 2);
		repeat (4) @(negedge sys_clk);
		chk(se1_n == 0, "brief SE1");
		ucodec_far_end_i.se(1'b1, 10);
		chk(se1_n > 0, "long SE1");
	endtask : t_err
	task results;
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	initial begin
		arst_n = 1'b0;
		tx_valid = 1'b0;
		tx_bit = 1'b0;
		repeat (8) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (40) @(negedge sys_clk);
		chk(speed_known === 1'b1 && speed_ls === 1'b0, "fs idle");
		t_rx();
		t_tx();
		t_err();
		ucodec_far_end_i.idle(1'b1, 40);
		chk(speed_known === 1'b1 && speed_ls === 1'b1, "ls idle");
		t_rx();
		results();
	end
endmodule : test_usb2_line_state_nrzi_codec
`default_nettype wire
